// >>> core/clock_startup_defines.vh
// shared offsets, fields, reset values and codes of the clock start-up control
`ifndef CLOCK_STARTUP_DEFINES_VH
`define CLOCK_STARTUP_DEFINES_VH

// register byte offsets on the bus
`define CS_FUSE_OFS 12'h000
`define CS_SLEEP_OFS 12'h004
`define CS_STATUS_OFS 12'h008

// fuse register layout and delivered value (1 = unprogrammed)
`define CS_FUSE_SRC_LSB 0
`define CS_FUSE_SRC_MSB 3
`define CS_FUSE_SUT_LSB 4
`define CS_FUSE_SUT_MSB 5
`define CS_FUSE_AMP_BIT 6
`define CS_FUSE_SRC_RESET 4'h1
`define CS_FUSE_SUT_RESET 2'h2
`define CS_FUSE_AMP_RESET 1'h1

// sleep register layout
`define CS_SLEEP_MODE_LSB 0
`define CS_SLEEP_MODE_MSB 2
`define CS_SLEEP_GO_BIT 3

// sleep mode codes
`define CS_MODE_IDLE 3'h0
`define CS_MODE_ADC_NR 3'h1
`define CS_MODE_POWER_DOWN 3'h2
`define CS_MODE_POWER_SAVE 3'h3
`define CS_MODE_STANDBY 3'h4
`define CS_MODE_EXT_STANDBY 3'h5

// clock source kinds
`define CS_KIND_CRYSTAL 3'h0
`define CS_KIND_LOW_FREQ 3'h1
`define CS_KIND_EXT_RC 3'h2
`define CS_KIND_INT_RC 3'h3
`define CS_KIND_EXT_CLK 3'h4

// fuse code boundaries
`define CS_SRC_CRYSTAL_MIN 4'ha
`define CS_SRC_LOW_FREQ 4'h9
`define CS_SRC_EXT_RC_MIN 4'h5
`define CS_SRC_INT_RC_MIN 4'h1

// amplifier range codes
`define CS_AMP_WIDE 2'h0
`define CS_AMP_0P4_0P9 2'h1
`define CS_AMP_0P9_3P0 2'h2
`define CS_AMP_3P0_8P0 2'h3

// wake count select and reset delay select codes
`define CS_WAKE_SHORT 2'h0
`define CS_WAKE_MID 2'h1
`define CS_WAKE_LONG 2'h2
`define CS_WAKE_OTHER 2'h3
`define CS_DLY_NONE 2'h0
`define CS_DLY_SHORT 2'h1
`define CS_DLY_LONG 2'h2

// status register field positions
`define CS_ST_STATE_LSB 0
`define CS_ST_DOM_LSB 5
`define CS_ST_KIND_LSB 10
`define CS_ST_AMP_LSB 13
`define CS_ST_WAKE_LSB 15
`define CS_ST_DLY_LSB 17

// ahb codes
`define CS_HTRANS_NONSEQ 2'h2
`define CS_HRESP_OKAY 1'h0

`endif

// >>> core/startup_counter.v
// counts tick pulses from zero up to a loaded target and flags completion
module startup_counter #(
    parameter W = 17
) (
    input wire hclk,
    input wire hresetn,
    input wire load,
    input wire [W-1:0] target,
    input wire tick,
    output reg done_r,
    output reg [W-1:0] count_r
);

    reg [W-1:0] target_r;

    // restart on load, then advance once per tick until the target is met
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= {W{1'b0}};
            target_r <= {W{1'b0}};
            done_r <= 1'b0;
        end else if (load) begin
            count_r <= {W{1'b0}};
            target_r <= target;
            done_r <= (target == {W{1'b0}});
        end else if (!done_r && tick) begin
            count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
            done_r <= (count_r + {{(W-1){1'b0}}, 1'b1}) == target_r;
        end
    end

endmodule

// >>> core/clock_source_startup_control.v
// clock source decode, reset and wake start-up sequencing, clock domain gating
//
// Contract
// - The four fuse bits pick crystal (1111-1010), low-frequency crystal (1001), external RC (1000-0101), internal RC (0100-0001) or external clock (0000).
// - A fuse bit holding one is unprogrammed and a fuse bit holding zero is programmed.
// - Waking from power-down or power-save waits a count of selected-source cycles before the core runs again.
// - Leaving reset adds a delay of 4096 or 65536 watchdog oscillator cycles when the settings call for one.
// - The fuses come up as source 0001 and start-up 10, the internal RC with its longest start-up.
// - For a crystal the upper three source bits pick the amplifier range, and a programmed swing option makes every code wide.
// - For a crystal the low source bit and start-up bits give a wake count of 258, 1K or 16K cycles.
// - For a crystal the same settings give no reset delay, 4.1 ms or 65 ms.
// - Core, I/O, flash, asynchronous timer and converter clocks are separate; each sleep mode halts its own set of them, never the asynchronous timer clock.
// - The flash clock runs and stops together with the core clock.
// - The asynchronous timer clock comes straight from the 32 kHz crystal and keeps running in sleep.
// - Asynchronous interrupt and two-wire address detection stay live while the I/O clock is halted.
// - The converter clock can run while core and I/O clocks are halted.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`include "clock_startup_defines.vh"

module clock_source_startup_control #(
    parameter WAKE_SHORT_CYCLES = 17'd258,
    parameter WAKE_MID_CYCLES = 17'd1024,
    parameter WAKE_LONG_CYCLES = 17'd16384,
    parameter WAKE_OTHER_CYCLES = 17'd6,
    parameter WDT_SHORT_CYCLES = 17'd4096,
    parameter WDT_LONG_CYCLES = 17'd65536
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire source_clk_pin,
    input wire watchdog_osc_pin,
    input wire wake_pin,
    output reg core_clk_en_r,
    output reg flash_clk_en_r,
    output reg io_clk_en_r,
    output reg adc_clk_en_r,
    output reg async_timer_clk_en_r,
    output reg async_detect_en_r
);

    // one-hot sequencer states
    localparam ST_RESET_DLY = 5'b00001;
    localparam ST_START = 5'b00010;
    localparam ST_RUN = 5'b00100;
    localparam ST_SLEEP = 5'b01000;
    localparam ST_LOAD = 5'b10000;

    reg [3:0] src_fuse_r;
    reg [1:0] sut_fuse_r;
    reg amp_fuse_r;
    reg [2:0] sleep_mode_r;
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg addr_we_r;
    reg addr_re_r;
    reg [11:0] addr_ofs_r;
    reg [2:0] src_sync_r;
    reg [2:0] wdt_sync_r;
    reg [1:0] wake_sync_r;
    reg load_r;
    reg [16:0] target_r;
    reg use_wdt_r;
    wire cnt_done;
    wire src_tick;
    wire wdt_tick;
    wire [2:0] kind;
    wire [1:0] amp_range;
    wire [1:0] wake_sel;
    wire [1:0] dly_sel;
    wire sleep_go;
    wire [4:0] dom_en;

    // source kind from the four source fuses
    function [2:0] source_kind;
        input [3:0] src;
        begin
            if (src >= `CS_SRC_CRYSTAL_MIN)
                source_kind = `CS_KIND_CRYSTAL;
            else if (src == `CS_SRC_LOW_FREQ)
                source_kind = `CS_KIND_LOW_FREQ;
            else if (src >= `CS_SRC_EXT_RC_MIN)
                source_kind = `CS_KIND_EXT_RC;
            else if (src >= `CS_SRC_INT_RC_MIN)
                source_kind = `CS_KIND_INT_RC;
            else
                source_kind = `CS_KIND_EXT_CLK;
        end
    endfunction

    // crystal amplifier range; a zero on the swing fuse means programmed
    function [1:0] amp_decode;
        input [3:0] src;
        input amp;
        begin
            if (!amp)
                amp_decode = `CS_AMP_WIDE;
            else if (src[3:1] == 3'h5)
                amp_decode = `CS_AMP_0P4_0P9;
            else if (src[3:1] == 3'h6)
                amp_decode = `CS_AMP_0P9_3P0;
            else
                amp_decode = `CS_AMP_3P0_8P0;
        end
    endfunction

    // wake count select from low source fuse and start-up fuses
    function [1:0] wake_decode;
        input [2:0] knd;
        input low;
        input [1:0] startup_time_fuses;
        begin
            if (knd != `CS_KIND_CRYSTAL)
                wake_decode = `CS_WAKE_OTHER;
            else if (!low && !startup_time_fuses[1])
                wake_decode = `CS_WAKE_SHORT;
            else if (!low || startup_time_fuses == 2'h0)
                wake_decode = `CS_WAKE_MID;
            else
                wake_decode = `CS_WAKE_LONG;
        end
    endfunction

    // reset delay select from low source fuse and start-up fuses
    function [1:0] dly_decode;
        input [2:0] knd;
        input low;
        input [1:0] startup_time_fuses;
        begin
            if (knd != `CS_KIND_CRYSTAL)
                dly_decode = (startup_time_fuses == 2'h0) ? `CS_DLY_NONE : (startup_time_fuses == 2'h2) ? `CS_DLY_LONG : `CS_DLY_SHORT;
            else if ({low, startup_time_fuses} == 3'h2 || {low, startup_time_fuses} == 3'h5)
                dly_decode = `CS_DLY_NONE;
            else if ({low, startup_time_fuses} == 3'h0 || {low, startup_time_fuses} == 3'h3 || {low, startup_time_fuses} == 3'h6)
                dly_decode = `CS_DLY_SHORT;
            else
                dly_decode = `CS_DLY_LONG;
        end
    endfunction

    // which domains a sleep mode leaves running: {io, adc}
    function [1:0] sleep_keep;
        input [2:0] mode;
        begin
            if (mode == `CS_MODE_ADC_NR)
                sleep_keep = 2'h1;
            else if (mode == `CS_MODE_POWER_DOWN || mode == `CS_MODE_POWER_SAVE ||
                     mode == `CS_MODE_STANDBY || mode == `CS_MODE_EXT_STANDBY)
                sleep_keep = 2'h0;
            else
                sleep_keep = 2'h3;
        end
    endfunction

    assign kind = source_kind(src_fuse_r);
    assign amp_range = amp_decode(src_fuse_r, amp_fuse_r);
    assign wake_sel = wake_decode(kind, src_fuse_r[0], sut_fuse_r);
    assign dly_sel = dly_decode(kind, src_fuse_r[0], sut_fuse_r);

    // two-stage synchronisers; source and watchdog edges taken after the second stage, wake used as a level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_sync_r <= 3'h0;
            wdt_sync_r <= 3'h0;
            wake_sync_r <= 2'h0;
        end else begin
            src_sync_r <= {src_sync_r[1:0], source_clk_pin};
            wdt_sync_r <= {wdt_sync_r[1:0], watchdog_osc_pin};
            wake_sync_r <= {wake_sync_r[0], wake_pin};
        end
    end

    assign src_tick = src_sync_r[1] & ~src_sync_r[2];
    assign wdt_tick = wdt_sync_r[1] & ~wdt_sync_r[2];

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = `CS_HRESP_OKAY;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_we_r <= 1'b0;
            addr_re_r <= 1'b0;
            addr_ofs_r <= 12'h000;
        end else if (hready) begin
            addr_we_r <= hsel & (htrans == `CS_HTRANS_NONSEQ) & hwrite;
            addr_re_r <= hsel & (htrans == `CS_HTRANS_NONSEQ) & ~hwrite;
            addr_ofs_r <= haddr[11:0];
        end
    end

    assign sleep_go = addr_we_r && addr_ofs_r == `CS_SLEEP_OFS && hwdata[`CS_SLEEP_GO_BIT];

    // mode that steers the domains; a sleep write's own mode governs its entry edge
    wire [2:0] mode_now = (addr_we_r && addr_ofs_r == `CS_SLEEP_OFS) ?
                          hwdata[`CS_SLEEP_MODE_MSB:`CS_SLEEP_MODE_LSB] : sleep_mode_r;

    // fuse and sleep mode registers written in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_fuse_r <= `CS_FUSE_SRC_RESET;
            sut_fuse_r <= `CS_FUSE_SUT_RESET;
            amp_fuse_r <= `CS_FUSE_AMP_RESET;
            sleep_mode_r <= `CS_MODE_IDLE;
        end else if (addr_we_r) begin
            if (addr_ofs_r == `CS_FUSE_OFS) begin
                src_fuse_r <= hwdata[`CS_FUSE_SRC_MSB:`CS_FUSE_SRC_LSB];
                sut_fuse_r <= hwdata[`CS_FUSE_SUT_MSB:`CS_FUSE_SUT_LSB];
                amp_fuse_r <= hwdata[`CS_FUSE_AMP_BIT];
            end else if (addr_ofs_r == `CS_SLEEP_OFS) begin
                sleep_mode_r <= hwdata[`CS_SLEEP_MODE_MSB:`CS_SLEEP_MODE_LSB];
            end
        end
    end

    // read data, decoded combinationally from the address phase captured at the following edge
    always @(*) begin
        hrdata = 32'h0000_0000;
        if (addr_re_r) begin
            if (addr_ofs_r == `CS_FUSE_OFS)
                hrdata = {25'h0, amp_fuse_r, sut_fuse_r, src_fuse_r};
            else if (addr_ofs_r == `CS_SLEEP_OFS)
                hrdata = {29'h0, sleep_mode_r};
            else if (addr_ofs_r == `CS_STATUS_OFS)
                hrdata = {13'h0, dly_sel, wake_sel, amp_range, kind, dom_en, state_r};
        end
    end

    // sequencer next state
    always @(*) begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET_DLY: begin
                if (cnt_done && !load_r)
                    state_nxt = ST_LOAD;
            end
            ST_LOAD: begin
                state_nxt = ST_START;
            end
            ST_START: begin
                if (cnt_done && !load_r)
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (sleep_go)
                    state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_sync_r[1]) begin
                    if (sleep_mode_r == `CS_MODE_POWER_DOWN || sleep_mode_r == `CS_MODE_POWER_SAVE)
                        state_nxt = ST_LOAD;
                    else
                        state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RESET_DLY;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            state_r <= ST_RESET_DLY;
        else
            state_r <= state_nxt;
    end

    // counter loading: watchdog delay after reset, source cycles before run
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_r <= 1'b1;
            use_wdt_r <= 1'b1;
            target_r <= 17'h0_0000;
        end else begin
            load_r <= 1'b0;
            if (load_r && state_r == ST_RESET_DLY) begin
                target_r <= target_r;
            end else if (state_r == ST_LOAD) begin
                load_r <= 1'b1;
                use_wdt_r <= 1'b0;
                if (wake_sel == `CS_WAKE_SHORT)
                    target_r <= WAKE_SHORT_CYCLES;
                else if (wake_sel == `CS_WAKE_MID)
                    target_r <= WAKE_MID_CYCLES;
                else if (wake_sel == `CS_WAKE_LONG)
                    target_r <= WAKE_LONG_CYCLES;
                else
                    target_r <= WAKE_OTHER_CYCLES;
            end
        end
    end

    // reset delay target follows the live fuses until the first load
    wire [16:0] wdt_target = (dly_sel == `CS_DLY_LONG) ? WDT_LONG_CYCLES :
                             (dly_sel == `CS_DLY_SHORT) ? WDT_SHORT_CYCLES : 17'h0_0000;

    startup_counter #(
        .W(17)
    ) u_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(load_r),
        .target(use_wdt_r ? wdt_target : target_r),
        .tick(use_wdt_r ? wdt_tick : src_tick),
        .done_r(cnt_done),
        .count_r()
    );

    assign dom_en = {async_detect_en_r, async_timer_clk_en_r, adc_clk_en_r, io_clk_en_r, core_clk_en_r};

    // domain clock enables
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_clk_en_r <= 1'b0;
            flash_clk_en_r <= 1'b0;
            io_clk_en_r <= 1'b0;
            adc_clk_en_r <= 1'b0;
            async_timer_clk_en_r <= 1'b1;
            async_detect_en_r <= 1'b1;
        end else begin
            core_clk_en_r <= (state_nxt == ST_RUN);
            flash_clk_en_r <= (state_nxt == ST_RUN);
            io_clk_en_r <= (state_nxt == ST_RUN) ||
                           (state_nxt == ST_SLEEP && sleep_keep(mode_now) == 2'h3);
            adc_clk_en_r <= (state_nxt == ST_RUN) ||
                            (state_nxt == ST_SLEEP && sleep_keep(mode_now) != 2'h0);
            async_timer_clk_en_r <= 1'b1;
            async_detect_en_r <= 1'b1;
        end
    end

endmodule

// >>> dv/clock_startup_properties.sv
// concurrent checks on the clock start-up control ports
module clock_startup_properties #(
    parameter WDT_LONG_CYCLES = 17'd65536
) (
    input logic hclk,
    input logic hresetn,
    input logic watchdog_osc_pin,
    input logic wake_pin,
    input logic hresp,
    input logic core_clk_en_r,
    input logic flash_clk_en_r,
    input logic io_clk_en_r,
    input logic adc_clk_en_r,
    input logic async_timer_clk_en_r,
    input logic async_detect_en_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wdt_q_r;
    logic seen_run_r;
    logic [16:0] wdt_cnt_r;
    // watchdog edges since reset, ahead of the design's synchroniser
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_q_r <= 1'b0;
            seen_run_r <= 1'b0;
            wdt_cnt_r <= 17'h0;
        end else begin
            wdt_q_r <= watchdog_osc_pin;
            seen_run_r <= seen_run_r | core_clk_en_r;
            if (watchdog_osc_pin && !wdt_q_r && wdt_cnt_r != 17'h1ffff) begin
                wdt_cnt_r <= wdt_cnt_r + 17'h1;
            end
        end
    end
    flash_tracks_a: assert property (flash_clk_en_r == core_clk_en_r)
        else $error("flash clock enable differs from core");
    timer_runs_a: assert property (async_timer_clk_en_r)
        else $error("async timer clock halted");
    detect_live_a: assert property (async_detect_en_r)
        else $error("async detection disabled");
    run_all_on_a: assert property ($rose(core_clk_en_r) |-> io_clk_en_r && adc_clk_en_r)
        else $error("core running without io or converter clock");
    io_needs_adc_a: assert property (io_clk_en_r && !core_clk_en_r |-> adc_clk_en_r)
        else $error("io clock on in sleep without converter clock");
    reset_gated_a: assert property ($rose(hresetn) |-> !core_clk_en_r ##1 !core_clk_en_r)
        else $error("core clock on straight after reset");
    first_run_delay_a: assert property ($rose(core_clk_en_r) && !seen_run_r |-> wdt_cnt_r >= WDT_LONG_CYCLES)
        else $error("core started before watchdog delay");
    wake_needs_pin_a: assert property ($rose(core_clk_en_r) && seen_run_r |-> $past(wake_pin, 2))
        else $error("core woke without wake event");
    bus_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    cover property ($fell(core_clk_en_r));
    cover property ($rose(core_clk_en_r) && seen_run_r);
    cover property (adc_clk_en_r && !io_clk_en_r);
    cover property (io_clk_en_r && !core_clk_en_r);
endmodule

bind clock_source_startup_control clock_startup_properties #(.WDT_LONG_CYCLES(WDT_LONG_CYCLES)) props_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .watchdog_osc_pin(watchdog_osc_pin),
    .wake_pin(wake_pin),
    .hresp(hresp),
    .core_clk_en_r(core_clk_en_r),
    .flash_clk_en_r(flash_clk_en_r),
    .io_clk_en_r(io_clk_en_r),
    .adc_clk_en_r(adc_clk_en_r),
    .async_timer_clk_en_r(async_timer_clk_en_r),
    .async_detect_en_r(async_detect_en_r)
);

// >>> dv/osc_source_model.sv
// free-running source oscillator and watchdog oscillator
module osc_source_model #(
    parameter int SRC_HALF = 3,
    parameter int WDT_HALF = 4
) (
    input logic hclk,
    output logic source_clk_pin = 1'b0,
    output logic watchdog_osc_pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int sc = 0;
    int wc = 0;
    // each level held several hclk so the synchroniser sees every edge
    always @(posedge hclk) begin
        sc <= (sc == SRC_HALF - 1) ? 0 : sc + 1;
        wc <= (wc == WDT_HALF - 1) ? 0 : wc + 1;
        if (sc == SRC_HALF - 1) source_clk_pin <= ~source_clk_pin;
        if (wc == WDT_HALF - 1) watchdog_osc_pin <= ~watchdog_osc_pin;
    end
endmodule

// >>> dv/test_clock_source_startup_control.sv
// testbench for the clock start-up control
`include "clock_startup_defines.vh"
`define check(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_clock_source_startup_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wake_pin = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire hready, hresp, src_pin, wdt_pin, core, flash, io, adc, atim, adet;
    wire [31:0] hrdata;
    int num_errors = 0, samples_checked = 0, cycles = 0, wcnt = 0, scnt = 0, ek, idx;
    always #2 hclk = ~hclk;
    always @(posedge wdt_pin) wcnt++;
    always @(posedge src_pin) scnt++;
    clock_source_startup_control #(.WAKE_SHORT_CYCLES(17'd5), .WAKE_MID_CYCLES(17'd12),
        .WAKE_LONG_CYCLES(17'd30), .WDT_SHORT_CYCLES(17'd20),
        .WDT_LONG_CYCLES(17'd40)) clock_source_startup_control_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .source_clk_pin(src_pin),
        .watchdog_osc_pin(wdt_pin), .wake_pin(wake_pin), .core_clk_en_r(core), .flash_clk_en_r(flash),
        .io_clk_en_r(io), .adc_clk_en_r(adc), .async_timer_clk_en_r(atim), .async_detect_en_r(adet));
    osc_source_model osc_source_model_inst (.hclk(hclk), .source_clk_pin(src_pin), .watchdog_osc_pin(wdt_pin));
    // one bus transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= `CS_HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task summarize;
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // sleep in one mode, check domains, then wake
    task automatic sleep_wake(input int m);
        xfer(1'b1, `CS_SLEEP_OFS, 32'h8 | m);
        @(posedge hclk);
        `check("sleep_en", 3'((m == 0) ? 3 : (m == 1) ? 1 : 0), {core, io, adc})
        `check("sleep_flash", 1'b0, flash)
        `check("async_en", 2'b11, {atim, adet})
        wake_pin <= 1'b1;
        scnt = 0;
        while (core !== 1'b1) @(posedge hclk);
        wake_pin <= 1'b0;
        if (m == 2 || m == 3) `check("wake_count", 1'b1, scnt >= 30 && scnt <= 33)
        `check("run_en", 4'hf, {core, flash, io, adc})
        repeat (4) @(posedge hclk);
    endtask
    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        wcnt = 0;
        @(posedge hclk);
        xfer(1'b0, `CS_FUSE_OFS, 0);
        `check("fuse_reset", 32'h61, rd)
        xfer(1'b0, `CS_STATUS_OFS, 0);
        `check("status_reset", 12'hb61, {rd[18:15], rd[12:10], rd[4:0]})
        xfer(1'b1, 32'h00c, 32'hffffffff);
        xfer(1'b0, 32'h00c, 0);
        `check("unmapped", 32'h0, rd)
        while (core !== 1'b1) @(posedge hclk);
        `check("reset_delay", 1'b1, wcnt >= 40 && wcnt <= 48)
        // every source, start-up and swing setting against the decode
        for (int s = 0; s < 16; s++) for (int u = 0; u < 4; u++) for (int a = 0; a < 2; a++) begin
            xfer(1'b1, `CS_FUSE_OFS, (a << 6) | (u << 4) | s);
            xfer(1'b0, `CS_STATUS_OFS, 0);
            ek = s >= 10 ? 0 : s == 9 ? 1 : s >= 5 ? 2 : s >= 1 ? 3 : 4;
            idx = (s % 2) * 4 + u;
            `check("kind", 3'(ek), rd[12:10])
            if (ek == 0) begin
                `check("amp", 2'(a ? s / 2 - 4 : 0), rd[14:13])
                `check("wake", 2'(idx < 2 ? 0 : idx < 5 ? 1 : 2), rd[16:15])
                `check("dly", 2'(idx % 3 == 2 ? 0 : idx % 3 == 0 ? 1 : 2), rd[18:17])
            end else begin
                `check("wake", 2'd3, rd[16:15])
                `check("dly", 2'(u == 0 ? 0 : u == 2 ? 2 : 1), rd[18:17])
            end
        end
        // crystal with the long wake count, not the 258-cycle one
        xfer(1'b1, `CS_FUSE_OFS, 32'h5b);
        for (int m = 0; m < 6; m++) sleep_wake(m);
        summarize();
    end
endmodule
